// file: core/sep_top.v
// Sync/error pin control with Avalon-MM register slave
`timescale 1ns/1ps
`include "sep_consts.vh"
module sep_top
#(
   parameter INT_ERR_W = 4
)
(
   input  wire                  I_CLOCK,
   input  wire                  I_RST,
   input  wire                  I_CE,
   input  wire [`SEP_ADDR_W-1:0] I_AVS_ADDRESS,
   input  wire                  I_AVS_READ,
   input  wire                  I_AVS_WRITE,
   input  wire [31:0]           I_AVS_WRITEDATA,
   output reg  [31:0]           O_AVS_READDATA,
   output reg                   O_AVS_WAITREQUEST,
   input  wire [INT_ERR_W-1:0]  I_INT_ERR,
   input  wire                  I_PIN_IN,
   output reg                   O_PIN_OUT,
   output reg                   O_PIN_OE,
   output reg                   O_SYNC_PULSE,
   output reg                   O_SYNC_HOLD,
   output reg                   O_IRQ
);
   wire                 pin_s;
   reg                  pin_prev_q;
   reg  [3:0]           cfg_q;
   reg  [`SEP_IRQ_W-1:0] irq_en_q;
   reg  [`SEP_IRQ_W-1:0] irq_clr;
   wire [`SEP_IRQ_W-1:0] irq_st;
   reg  [`SEP_IRQ_W-1:0] irq_set;
   reg                  ext_err_q;
   reg  [15:0]          sync_cnt_q;
   reg                  err_prev_q;
   wire                 sync_en;
   wire [1:0]           mode;
   wire                 any_err;
   wire                 acc;
   wire                 wr_take;
   reg                  ack_q;
   reg  [31:0]          rd_d;

   sep_sync2 u_sync
   (
      .i_clk (I_CLOCK),
      .i_rst (I_RST),
      .i_ce  (I_CE),
      .i_d   (I_PIN_IN),
      .o_q   (pin_s)
   );

   sep_sticky #(.W(`SEP_IRQ_W)) u_irq
   (
      .i_clk   (I_CLOCK),
      .i_rst   (I_RST),
      .i_ce    (I_CE),
      .i_set   (irq_set),
      .i_clr   (irq_clr),
      .o_flags (irq_st)
   );

   assign sync_en = cfg_q[`SEP_CFG_SYNC_EN];
   assign mode    = cfg_q[`SEP_CFG_MODE_HI:`SEP_CFG_MODE_LO];
   assign any_err = ext_err_q | (|I_INT_ERR);
   // One wait state on every access, so readdata is registered
   assign acc     = (I_AVS_READ | I_AVS_WRITE) & ~ack_q;
   // Writes land only at the edge where the master sees waitrequest low
   assign wr_take = I_AVS_WRITE & ~O_AVS_WAITREQUEST;

   always @*
   begin
      irq_clr = {`SEP_IRQ_W{1'b0}};
      if (wr_take && I_AVS_ADDRESS == `SEP_OFF_IRQ_CLEAR)
         irq_clr = I_AVS_WRITEDATA[`SEP_IRQ_W-1:0];
      irq_set = {`SEP_IRQ_W{1'b0}};
      irq_set[`SEP_IRQ_SYNC]    = sync_en & pin_prev_q & ~pin_s;
      irq_set[`SEP_IRQ_EXT_ERR] = ~sync_en & (mode == `SEP_MODE_ERR_IN) & ~pin_s & ~ext_err_q;
      irq_set[`SEP_IRQ_INT_ERR] = (|I_INT_ERR) & ~err_prev_q;
   end

   always @*
   begin
      rd_d = 32'h0;
      case (I_AVS_ADDRESS)
         `SEP_OFF_IO_CONFIG:  rd_d[3:0] = cfg_q;
         `SEP_OFF_ERR_STATUS: rd_d[INT_ERR_W:0] = {I_INT_ERR, ext_err_q};
         `SEP_OFF_IRQ_STATUS: rd_d[`SEP_IRQ_W-1:0] = irq_st;
         `SEP_OFF_IRQ_ENABLE: rd_d[`SEP_IRQ_W-1:0] = irq_en_q;
         `SEP_OFF_SYNC_COUNT: rd_d[15:0] = sync_cnt_q;
         default:             rd_d = 32'h0;
      endcase
   end

   always @(posedge I_CLOCK)
   begin
      if (I_RST)
      begin
         cfg_q             <= `SEP_CFG_RESET;
         irq_en_q          <= {`SEP_IRQ_W{1'b0}};
         ext_err_q         <= 1'b0;
         sync_cnt_q        <= 16'h0;
         pin_prev_q        <= 1'b1;
         err_prev_q        <= 1'b0;
         ack_q             <= 1'b0;
         O_AVS_READDATA    <= 32'h0;
         O_AVS_WAITREQUEST <= 1'b1;
         O_PIN_OUT         <= 1'b0;
         O_PIN_OE          <= 1'b0;
         O_SYNC_PULSE      <= 1'b0;
         O_SYNC_HOLD       <= 1'b0;
         O_IRQ             <= 1'b0;
      end
      else if (I_CE)
      begin
         pin_prev_q <= pin_s;
         err_prev_q <= |I_INT_ERR;
         ack_q      <= acc;
         O_AVS_WAITREQUEST <= ~acc;
         if (acc && I_AVS_READ)
            O_AVS_READDATA <= rd_d;
         if (wr_take && I_AVS_ADDRESS == `SEP_OFF_IO_CONFIG)
            cfg_q <= I_AVS_WRITEDATA[3:0];
         if (wr_take && I_AVS_ADDRESS == `SEP_OFF_IRQ_ENABLE)
            irq_en_q <= I_AVS_WRITEDATA[`SEP_IRQ_W-1:0];
         // Set wins over a same-cycle clear from error status write
         if (~sync_en && mode == `SEP_MODE_ERR_IN && ~pin_s)
            ext_err_q <= 1'b1;
         else if (wr_take && I_AVS_ADDRESS == `SEP_OFF_ERR_STATUS
                  && I_AVS_WRITEDATA[`SEP_ST_EXT_ERR])
            ext_err_q <= 1'b0;
         // Sync: filters held while low, restart on falling edge
         O_SYNC_PULSE <= sync_en & pin_prev_q & ~pin_s;
         O_SYNC_HOLD  <= sync_en & ~pin_s;
         if (sync_en && pin_prev_q && ~pin_s)
            sync_cnt_q <= sync_cnt_q + 16'h1;
         if (sync_en)
         begin
            O_PIN_OE  <= 1'b0;
            O_PIN_OUT <= 1'b0;
         end
         else
         begin
            case (mode)
               `SEP_MODE_ERR_OUT:
               begin
                  O_PIN_OE  <= any_err;
                  O_PIN_OUT <= 1'b0;
               end
               `SEP_MODE_GP_OUT:
               begin
                  O_PIN_OE  <= 1'b1;
                  O_PIN_OUT <= cfg_q[`SEP_CFG_LEVEL];
               end
               default:
               begin
                  O_PIN_OE  <= 1'b0;
                  O_PIN_OUT <= 1'b0;
               end
            endcase
         end
         O_IRQ <= |((irq_st | irq_set) & irq_en_q);
      end
   end
endmodule // sep_top

// file: core/sep_consts.vh
// Constants for the sync/error pin control block
`ifndef SEP_CONSTS_VH
`define SEP_CONSTS_VH
`define SEP_ADDR_W          3
`define SEP_OFF_IO_CONFIG   3'h0
`define SEP_OFF_ERR_STATUS  3'h1
`define SEP_OFF_IRQ_STATUS  3'h2
`define SEP_OFF_IRQ_CLEAR   3'h3
`define SEP_OFF_IRQ_ENABLE  3'h4
`define SEP_OFF_SYNC_COUNT  3'h5
`define SEP_CFG_SYNC_EN     0
`define SEP_CFG_MODE_LO     1
`define SEP_CFG_MODE_HI     2
`define SEP_CFG_LEVEL       3
`define SEP_CFG_RESET       4'h1
`define SEP_MODE_ERR_IN     2'h0
`define SEP_MODE_ERR_OUT    2'h1
`define SEP_MODE_GP_OUT     2'h2
`define SEP_ST_EXT_ERR      0
`define SEP_ST_INT_ERR_LO   1
`define SEP_IRQ_SYNC        0
`define SEP_IRQ_EXT_ERR     1
`define SEP_IRQ_INT_ERR     2
`define SEP_IRQ_W           3
`endif

// file: core/sep_sync2.v
// Two-flop synchroniser for the pin input
`timescale 1ns/1ps
module sep_sync2
(
   input  wire       i_clk,
   input  wire       i_rst,
   input  wire       i_ce,
   input  wire       i_d,
   output reg        o_q
);
   reg meta_q;
   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         meta_q <= 1'b1;
         o_q    <= 1'b1;
      end
      else if (i_ce)
      begin
         meta_q <= i_d;
         o_q    <= meta_q;
      end
   end
endmodule // sep_sync2

// file: core/sep_sticky.v
// Sticky event bits: set wins over clear
`timescale 1ns/1ps
module sep_sticky
#(
   parameter W = 3
)
(
   input  wire         i_clk,
   input  wire         i_rst,
   input  wire         i_ce,
   input  wire [W-1:0] i_set,
   input  wire [W-1:0] i_clr,
   output reg  [W-1:0] o_flags
);
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1)
      begin : g_bit
         always @(posedge i_clk)
         begin
            if (i_rst)
               o_flags[g] <= 1'b0;
            else if (i_ce)
            begin
               if (i_set[g])
                  o_flags[g] <= 1'b1;
               else if (i_clr[g])
                  o_flags[g] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule // sep_sticky

// file: bench/sep_line_model.sv
// Pulled-up shared error line with one more party on it
`timescale 1ns/1ps
module sep_line_model
(
   input  wire logic i_out,
   input  wire logic i_oe,
   input  wire logic i_pull_low,
   output wire logic o_line
);
   // Any party pulling low wins
   assign o_line = (i_pull_low || (i_oe && !i_out)) ? 1'b0 : 1'b1;
endmodule // sep_line_model

// file: bench/sep_checker.sv
// Port assertions for the sync/error pin block
`timescale 1ns/1ps
`include "sep_consts.vh"
module sep_checker
#(
   parameter INT_ERR_W = 4
)
(
   input wire logic                   I_CLOCK,
   input wire logic                   I_RST,
   input wire logic                   I_CE,
   input wire logic [`SEP_ADDR_W-1:0] I_AVS_ADDRESS,
   input wire logic                   I_AVS_READ,
   input wire logic                   I_AVS_WRITE,
   input wire logic [31:0]            I_AVS_WRITEDATA,
   input wire logic [31:0]            O_AVS_READDATA,
   input wire logic                   O_AVS_WAITREQUEST,
   input wire logic [INT_ERR_W-1:0]   I_INT_ERR,
   input wire logic                   I_PIN_IN,
   input wire logic                   O_PIN_OUT,
   input wire logic                   O_PIN_OE,
   input wire logic                   O_SYNC_PULSE,
   input wire logic                   O_SYNC_HOLD,
   input wire logic                   O_IRQ
);
   logic [3:0] cfg_q;
   wire        sy = cfg_q[0];
   wire  [1:0] md = cfg_q[2:1];
   // Shadow of the config word, taken at the master's accept edge
   always_ff @(posedge I_CLOCK)
      if (I_RST)
         cfg_q <= `SEP_CFG_RESET;
      else if (I_CE && I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == 3'h0)
         cfg_q <= I_AVS_WRITEDATA[3:0];
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);
   sequence s_req; $rose(I_AVS_READ || I_AVS_WRITE); endsequence
   sequence s_od; (!sy && md == `SEP_MODE_ERR_OUT)[*2]; endsequence
   a_sync_no_drive: assert property (sy[*2] |-> !O_PIN_OE)
      else $error("pin driven in sync mode");
   a_sync_pulse_one: assert property (O_SYNC_PULSE |=> !O_SYNC_PULSE)
      else $error("sync pulse too long");
   a_pulse_with_hold: assert property (O_SYNC_PULSE |-> O_SYNC_HOLD)
      else $error("sync pulse without hold");
   a_idle_no_drive: assert property ((!sy && md != 1 && md != 2)[*2] |-> !O_PIN_OE)
      else $error("pin driven in input mode");
   a_od_low_only: assert property (s_od ##0 O_PIN_OE |-> !O_PIN_OUT)
      else $error("error output drove high");
   a_err_pull: assert property (s_od ##0 (|I_INT_ERR)[*2] |-> O_PIN_OE && !O_PIN_OUT)
      else $error("error line not pulled");
   a_gp_level: assert property ((!sy && md == 2)[*2] |-> O_PIN_OE && O_PIN_OUT == $past(cfg_q[3]))
      else $error("general output level wrong");
   a_bus_wait: assert property (s_req |-> ##[1:2] !O_AVS_WAITREQUEST)
      else $error("bus answer late");
endmodule // sep_checker
bind sep_top sep_checker #(.INT_ERR_W(INT_ERR_W)) u_sep_checker (.*);

// file: bench/sep_top_tb.sv
// Self-checking bench for the sync/error pin block
`timescale 1ns/1ps
`include "sep_consts.vh"
`define CHK(n,e,g) begin n_checks++; if ((g) !== (e)) begin failures++; \
$display("mismatch %s exp %h got %h", n, e, g); end end
module sep_top_tb;
   logic        clk = 0, rst = 1, rd = 0, wr = 0, pull = 0;
   logic        line, pout, poe, spul, shold, irq, wreq;
   logic [2:0]  addr = 0;
   logic [3:0]  ierr = 0;
   logic [31:0] wd = 0, rdat, q;
   int          failures = 0, n_checks = 0, n_pulse = 0;
   initial forever #50 clk = ~clk;
   always @(posedge clk)
      if (spul === 1'b1)
         n_pulse <= n_pulse + 1;
   sep_top u_sep_top (.I_CLOCK(clk), .I_RST(rst), .I_CE(1'b1), .I_AVS_ADDRESS(addr),
      .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .O_AVS_READDATA(rdat),
      .O_AVS_WAITREQUEST(wreq), .I_INT_ERR(ierr), .I_PIN_IN(line), .O_PIN_OUT(pout),
      .O_PIN_OE(poe), .O_SYNC_PULSE(spul), .O_SYNC_HOLD(shold), .O_IRQ(irq));
   sep_line_model u_sep_line_model (.i_out(pout), .i_oe(poe), .i_pull_low(pull),
      .o_line(line));
   task complete_run;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Holds the request until waitrequest is seen low at a rising edge
   task acc(input logic w, input logic [2:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wreq !== 1'b0 && n < 20);
      if (wreq !== 1'b0)
      begin
         failures++;
         complete_run();
      end
      else
      begin
         q = rdat;
         wr <= 0;
         rd <= 0;
      end
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 0;
      acc(0, `SEP_OFF_IO_CONFIG, 0);
      `CHK("cfg", 32'h1, q)
      acc(0, 3'h7, 0);
      `CHK("unmapped", 32'h0, q)
      acc(1, `SEP_OFF_IRQ_ENABLE, 32'h7);
      @(posedge clk) pull <= 1;
      cyc(6);
      `CHK("hold", 1'b1, shold)
      `CHK("sync oe", 1'b0, poe)
      @(posedge clk) pull <= 0;
      cyc(6);
      `CHK("hold off", 1'b0, shold)
      `CHK("sync pulses", 1, n_pulse)
      acc(0, `SEP_OFF_SYNC_COUNT, 0);
      `CHK("sync count", 32'h1, q)
      `CHK("irq on", 1'b1, irq)
      acc(0, `SEP_OFF_IRQ_STATUS, 0);
      `CHK("irq status sync", 32'h1, q)
      acc(1, `SEP_OFF_IRQ_CLEAR, 32'h7);
      cyc(2);
      `CHK("irq off", 1'b0, irq)
      $display("sync test done");
      acc(1, `SEP_OFF_IO_CONFIG, 32'h0);
      @(posedge clk) pull <= 1;
      cyc(6);
      @(posedge clk) pull <= 0;
      cyc(6);
      acc(0, `SEP_OFF_ERR_STATUS, 0);
      `CHK("ext err", 32'h1, q)
      `CHK("err in oe", 1'b0, poe)
      `CHK("no pulse", 1, n_pulse)
      acc(0, `SEP_OFF_IRQ_STATUS, 0);
      `CHK("irq status ext", 32'h2, q)
      acc(1, `SEP_OFF_ERR_STATUS, 32'h1);
      acc(0, `SEP_OFF_ERR_STATUS, 0);
      `CHK("ext clear", 32'h0, q)
      acc(1, `SEP_OFF_IRQ_CLEAR, 32'h7);
      $display("error input test done");
      acc(1, `SEP_OFF_IO_CONFIG, 32'h2);
      @(posedge clk) ierr <= 4'h9;
      cyc(4);
      `CHK("od low", 1'b0, line)
      `CHK("int irq", 1'b1, irq)
      acc(0, `SEP_OFF_ERR_STATUS, 0);
      `CHK("int err", 32'h12, q)
      acc(0, `SEP_OFF_IRQ_STATUS, 0);
      `CHK("irq status int", 32'h4, q)
      acc(1, `SEP_OFF_IRQ_ENABLE, 32'h0);
      cyc(2);
      `CHK("irq masked", 1'b0, irq)
      @(posedge clk) ierr <= 0;
      cyc(4);
      `CHK("od free", 1'b1, line)
      `CHK("od oe", 1'b0, poe)
      $display("error output test done");
      for (int l = 0; l < 2; l++)
      begin
         acc(1, `SEP_OFF_IO_CONFIG, {28'h0, l[0], 3'h4});
         cyc(3);
         `CHK("gp oe", 1'b1, poe)
         `CHK("gp level", l[0], line)
      end
      acc(1, `SEP_OFF_IO_CONFIG, 32'h6);
      cyc(3);
      `CHK("mode 3 oe", 1'b0, poe)
      $display("output mode test done");
      complete_run();
   end
endmodule // sep_top_tb
